/* design/fsp_pkg.sv */
/*
 * fsp_pkg: constants, register offsets and types for the axis fault stop policy block.
 * Assumes a 32-bit classic Wishbone slave port with word-aligned registers.
 */
package fsp_pkg;

   // ----------------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [7:0] FSP_OFF_EMG_POL = 8'h00;
   localparam logic [7:0] FSP_OFF_CMD_POL = 8'h04;
   localparam logic [7:0] FSP_OFF_POS_POL = 8'h08;
   localparam logic [7:0] FSP_OFF_NEG_POL = 8'h0C;
   localparam logic [7:0] FSP_OFF_DECEL = 8'h10;
   localparam logic [7:0] FSP_OFF_SETTLE = 8'h14;
   localparam logic [7:0] FSP_OFF_STATUS = 8'h18;

   // ----------------------------------------------------------------------
   // field widths, limits and reset values
   // ----------------------------------------------------------------------
   localparam int FSP_POL_W = 3;
   localparam logic [2:0] FSP_POL_MAX = 3'h5;
   localparam logic [2:0] FSP_EMG_POL_RST = 3'h0;
   localparam logic [2:0] FSP_FAULT_POL_RST = 3'h1;
   localparam logic [2:0] FSP_POL_HIGH_MIN = 3'h3;
   localparam int FSP_DECEL_W = 14;
   localparam logic [13:0] FSP_DECEL_MIN = 14'h0001;
   localparam logic [13:0] FSP_DECEL_MAX = 14'h270F;
   localparam logic [13:0] FSP_DECEL_RST = 14'h0001;
   localparam logic FSP_SETTLE_RST = 1'b1;

   // ----------------------------------------------------------------------
   // fault sources, in priority order, and controller states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      FSP_SRC_EMG = 2'h0,
      FSP_SRC_CMD = 2'h1,
      FSP_SRC_POS = 2'h2,
      FSP_SRC_NEG = 2'h3
   } fsp_src_t;

   typedef enum logic [1:0] {
      FSP_ST_IDLE = 2'h0,
      FSP_ST_TAKE = 2'h1,
      FSP_ST_STOP = 2'h3,
      FSP_ST_DONE = 2'h2
   } fsp_state_t;

endpackage : fsp_pkg

/* design/fsp_policy_reg.sv */
/*
 * fsp_policy_reg: one 0..5 stop policy selector, writable over the bus.
 * Assumes the caller decodes the address and strobes wr_en at the bus ack edge.
 */
`timescale 1ns/1ps
module fsp_policy_reg
   import fsp_pkg::*;
#(
   parameter logic [2:0] RESET_VALUE = 3'h0
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [2:0] wr_data,
   output logic [2:0] policy
);

   // ----------------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------------
   if (RESET_VALUE > FSP_POL_MAX) begin : g_bad_reset
      $error("policy reset value out of range");
   end

   logic [2:0] pol_q;

   // out-of-range writes are dropped so the selector never holds 6 or 7
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pol_q <= RESET_VALUE;
      end else if (wr_en && (wr_data <= FSP_POL_MAX)) begin
         pol_q <= wr_data;
      end
   end

   assign policy = pol_q;

   AST_POL_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      pol_q <= FSP_POL_MAX)
      else $error("policy selector out of range");

endmodule : fsp_policy_reg

/* design/fsp_axis_fault_stop.sv */
/*
 * fsp_axis_fault_stop: fault reaction policy for one servo axis, with its
 * settings reached over classic Wishbone.
 * Assumes the motion core reports stop completion, control hand-back and
 * move ends on single-clock inputs synchronous to clk_sys.
 */
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps

module fsp_axis_fault_stop
   import fsp_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   // classic Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // fault event sources
   input wire logic board_emergency_request,
   input wire logic cmd_rate_fault,
   input wire logic pos_overtravel_fault,
   input wire logic neg_overtravel_fault,
   // motion core side
   input wire logic host_follow_active,
   input wire logic builtin_ctrl_ready,
   input wire logic stop_complete,
   input wire logic move_end,
   input wire logic move_positioning,
   input wire logic homing_active,
   output logic ctrl_takeover,
   output logic stop_request,
   output logic stop_immediate,
   output logic servo_off,
   output logic [13:0] abort_decel_time,
   output logic settle_wait_start
);

   // ----------------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------------
   if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must lie between 8 and 32");
   end

   // ----------------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------------
   logic ack_q;
   logic [31:0] rdat_q;
   logic wr_fire;
   logic [7:0] adr8;
   logic [2:0] pol_emg, pol_cmd, pol_pos, pol_neg;
   logic [13:0] decel_q;
   logic settle_en_q;
   logic [31:0] rdat_d;
   fsp_state_t state_q, state_d;
   fsp_src_t src_q;
   logic [2:0] code_q;
   logic host_q;
   logic servo_off_q;

   assign adr8 = wb_adr_i[7:0];
   // writes land on the edge where the master samples ack
   assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];

   // one wait state, ack drops the cycle after it was given
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      end
   end

   // read mux; unmapped addresses read zero and still ack
   always_comb begin
      rdat_d = 32'h0000_0000;
      if (adr8 == FSP_OFF_EMG_POL) begin
         rdat_d[2:0] = pol_emg;
      end else if (adr8 == FSP_OFF_CMD_POL) begin
         rdat_d[2:0] = pol_cmd;
      end else if (adr8 == FSP_OFF_POS_POL) begin
         rdat_d[2:0] = pol_pos;
      end else if (adr8 == FSP_OFF_NEG_POL) begin
         rdat_d[2:0] = pol_neg;
      end else if (adr8 == FSP_OFF_DECEL) begin
         rdat_d[13:0] = decel_q;
      end else if (adr8 == FSP_OFF_SETTLE) begin
         rdat_d[0] = settle_en_q;
      end else if (adr8 == FSP_OFF_STATUS) begin
         rdat_d[1:0] = state_q;
         rdat_d[3:2] = src_q;
         rdat_d[6:4] = code_q;
         rdat_d[7] = host_q;
         rdat_d[8] = servo_off_q;
      end
   end

   // read data captured as ack rises, held until the next access
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdat_q <= 32'h0000_0000;
      end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;

   // ----------------------------------------------------------------------
   // settings
   // ----------------------------------------------------------------------
   fsp_policy_reg #(.RESET_VALUE(FSP_EMG_POL_RST)) u_pol_emg (
      .clk_sys(clk_sys), .rst_n(rst_n),
      .wr_en(wr_fire && adr8 == FSP_OFF_EMG_POL), .wr_data(wb_dat_i[2:0]), .policy(pol_emg));
   fsp_policy_reg #(.RESET_VALUE(FSP_FAULT_POL_RST)) u_pol_cmd (
      .clk_sys(clk_sys), .rst_n(rst_n),
      .wr_en(wr_fire && adr8 == FSP_OFF_CMD_POL), .wr_data(wb_dat_i[2:0]), .policy(pol_cmd));
   fsp_policy_reg #(.RESET_VALUE(FSP_FAULT_POL_RST)) u_pol_pos (
      .clk_sys(clk_sys), .rst_n(rst_n),
      .wr_en(wr_fire && adr8 == FSP_OFF_POS_POL), .wr_data(wb_dat_i[2:0]), .policy(pol_pos));
   fsp_policy_reg #(.RESET_VALUE(FSP_FAULT_POL_RST)) u_pol_neg (
      .clk_sys(clk_sys), .rst_n(rst_n),
      .wr_en(wr_fire && adr8 == FSP_OFF_NEG_POL), .wr_data(wb_dat_i[2:0]), .policy(pol_neg));

   // decel time: writes outside 1..9999 are dropped, low byte lanes only
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         decel_q <= FSP_DECEL_RST;
      end else if (wr_fire && adr8 == FSP_OFF_DECEL && wb_sel_i[1]
                   && wb_dat_i[31:14] == 18'h0_0000 && wb_dat_i[13:0] >= FSP_DECEL_MIN
                   && wb_dat_i[13:0] <= FSP_DECEL_MAX) begin
         decel_q <= wb_dat_i[13:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         settle_en_q <= FSP_SETTLE_RST;
      end else if (wr_fire && adr8 == FSP_OFF_SETTLE) begin
         settle_en_q <= wb_dat_i[0];
      end
   end

   assign abort_decel_time = decel_q;

   // ----------------------------------------------------------------------
   // fault reaction
   // ----------------------------------------------------------------------
   logic any_fault;
   fsp_src_t src_d;
   logic [2:0] code_d;
   logic code_high, code_off_now, code_off_after;

   assign any_fault = board_emergency_request || cmd_rate_fault || pos_overtravel_fault || neg_overtravel_fault;

   // fixed priority: emergency first, then command rate, plus, minus
   always_comb begin
      src_d = FSP_SRC_NEG;
      code_d = pol_neg;
      if (board_emergency_request) begin
         src_d = FSP_SRC_EMG;
         code_d = pol_emg;
      end else if (cmd_rate_fault) begin
         src_d = FSP_SRC_CMD;
         code_d = pol_cmd;
      end else if (pos_overtravel_fault) begin
         src_d = FSP_SRC_POS;
         code_d = pol_pos;
      end
   end

   // decode of the captured code, shared by both operating modes
   assign code_high = code_q >= FSP_POL_HIGH_MIN;
   // the capture edge still holds the previous code, so decode the incoming one there
   assign code_off_now = (state_q == FSP_ST_IDLE) ? (code_d == 3'h2 || code_d == 3'h5)
      : (code_q == 3'h2 || code_q == 3'h5);
   assign code_off_after = code_q == 3'h1 || code_q == 3'h4;

   // next state; DONE waits for every source to clear before rearming
   always_comb begin
      state_d = state_q;
      case (state_q)
         FSP_ST_IDLE: begin
            if (any_fault) begin
               state_d = host_follow_active ? FSP_ST_TAKE : FSP_ST_STOP;
            end
         end
         FSP_ST_TAKE: begin
            if (builtin_ctrl_ready) begin
               state_d = FSP_ST_STOP;
            end
         end
         FSP_ST_STOP: begin
            if (stop_complete) begin
               state_d = FSP_ST_DONE;
            end
         end
         FSP_ST_DONE: begin
            if (!any_fault) begin
               state_d = FSP_ST_IDLE;
            end
         end
         default: state_d = FSP_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= FSP_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // capture source, code and mode only on first detection
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         src_q <= FSP_SRC_EMG;
         code_q <= 3'h0;
         host_q <= 1'b0;
      end else if (state_q == FSP_ST_IDLE && any_fault) begin
         src_q <= src_d;
         code_q <= code_d;
         host_q <= host_follow_active;
      end
   end

   // servo off: at stop start for 2/5, at stop end for 1/4, never for 0/3
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         servo_off_q <= 1'b0;
      end else if (state_d == FSP_ST_IDLE) begin
         servo_off_q <= 1'b0;
      end else if (state_d == FSP_ST_STOP && code_off_now) begin
         servo_off_q <= 1'b1;
      end else if (state_d == FSP_ST_DONE && code_off_after) begin
         servo_off_q <= 1'b1;
      end
   end

   // stop_immediate stays low for 0..2 and high for 3..5; servo_off, not stop_immediate, keeps the servo on for 0/3
   assign ctrl_takeover = state_q == FSP_ST_TAKE;
   assign stop_request = state_q == FSP_ST_STOP;
   assign stop_immediate = state_q == FSP_ST_STOP && code_high;
   assign servo_off = servo_off_q;

   // ----------------------------------------------------------------------
   // settling wait
   // ----------------------------------------------------------------------
   logic settle_q;

   // homing forces the wait; non-positioning moves wait only while homing
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         settle_q <= 1'b0;
      end else begin
         settle_q <= move_end && (homing_active || (move_positioning && settle_en_q));
      end
   end

   assign settle_wait_start = settle_q;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   AST_TAKEOVER_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_q == FSP_ST_IDLE && any_fault && host_follow_active) |=> ctrl_takeover && !stop_request)
      else $error("host follow-up fault did not take control first");
   AST_BUILTIN_DIRECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_q == FSP_ST_IDLE && any_fault && !host_follow_active) |=> stop_request && !ctrl_takeover)
      else $error("built-in fault did not start a stop");
   AST_OFF_NOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (stop_request && (code_q == 3'h2 || code_q == 3'h5)) |-> servo_off)
      else $error("servo not off while stopping for code 2 or 5");
   AST_OFF_AFTER: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (stop_request && (code_q == 3'h1 || code_q == 3'h4)) |-> (!servo_off and (stop_complete |=> servo_off)))
      else $error("servo off timing wrong for code 1 or 4");
   AST_KEEP_ON: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_q != FSP_ST_IDLE && (code_q == 3'h0 || code_q == 3'h3)) |-> !servo_off)
      else $error("servo switched off for code 0 or 3");
   AST_LEVEL: assert property (@(posedge clk_sys) disable iff (!rst_n)
      stop_request |-> (stop_immediate == (code_q > 3'h2)))
      else $error("stop level does not match policy code");
   AST_CODE_HELD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_q != FSP_ST_IDLE && $past(state_q) != FSP_ST_IDLE) |-> $stable(code_q) && $stable(src_q))
      else $error("captured policy changed during a stop");
   AST_DECEL_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      abort_decel_time >= 14'h0001 && abort_decel_time <= 14'h270F)
      else $error("abort decel time out of range");
   AST_NO_SETTLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (move_end && !move_positioning && !homing_active) |=> !settle_wait_start)
      else $error("settling wait on a move without positioning");
   AST_HOMING_SETTLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (move_end && homing_active) |=> settle_wait_start)
      else $error("homing end without settling wait");
   AST_SETTLE_EN: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (move_end && move_positioning && !homing_active) |=> (settle_wait_start == $past(settle_en_q)))
      else $error("settling wait does not follow enable");
   AST_ACK_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   COV_HOST_STOP: cover property (@(posedge clk_sys) disable iff (!rst_n) ctrl_takeover ##1 stop_request);
   COV_OFF_NOW: cover property (@(posedge clk_sys) disable iff (!rst_n) stop_request && servo_off);
   COV_DONE: cover property (@(posedge clk_sys) disable iff (!rst_n) state_q == FSP_ST_DONE ##1 state_q == FSP_ST_IDLE);
   COV_HOMING: cover property (@(posedge clk_sys) disable iff (!rst_n) settle_wait_start && !settle_en_q);

endmodule : fsp_axis_fault_stop

/* verification/fsp_motion_core_model.sv */
/*
 * fsp_motion_core_model: behavioural motion core that answers the fault stop block.
 * Assumes ctrl_takeover and stop_request are levels synchronous to clk_sys.
 */
`timescale 1ns/1ps
module fsp_motion_core_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ctrl_takeover,
   input wire logic stop_request,
   input wire logic [3:0] delay,
   output logic builtin_ctrl_ready,
   output logic stop_complete
);
   // ----------------------------------------------------------------------
   // answer timing
   // ----------------------------------------------------------------------
   logic [3:0] cnt_q;
   logic [1:0] req_q;
   logic req_chg;

   assign req_chg = {ctrl_takeover, stop_request} != req_q;

   // count from each change of either request and never answer on the change edge itself,
   // so a stale count cannot answer early; a long delay leaves room for bus traffic mid-reaction
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
         req_q <= 2'h0;
         builtin_ctrl_ready <= 1'b0;
         stop_complete <= 1'b0;
      end else begin
         req_q <= {ctrl_takeover, stop_request};
         if (req_chg) begin
            cnt_q <= 4'h0;
         end else if (cnt_q != 4'hF) begin
            cnt_q <= cnt_q + 4'h1;
         end
         builtin_ctrl_ready <= ctrl_takeover && !req_chg && (cnt_q >= delay);
         stop_complete <= stop_request && !req_chg && (cnt_q >= delay);
      end
   end
endmodule : fsp_motion_core_model

/* verification/fsp_axis_fault_stop_tb_top.sv */
/*
 * fsp_axis_fault_stop_tb_top: self-checking bench for the fault stop block.
 * Assumes the motion core model answers takeover and stop requests after a set delay.
 */
`timescale 1ns/1ps
module fsp_axis_fault_stop_tb_top;
   import fsp_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0, dat_o, rd;
   logic ack, ready, complete, take, stop_req, stop_imm, srv_off, settle_pulse, took;
   logic [3:0] faults = 4'h0, delay = 4'h0;
   logic host = 1'b0, move_end = 1'b0, move_pos = 1'b0, homing = 1'b0;
   logic [13:0] decel;
   int miscompares = 0, checks = 0, n;
   logic [31:0] exp_dec;
   logic [1:0] src;

   // ----------------------------------------------------------------------
   // clock, design and partner
   // ----------------------------------------------------------------------
   always #50 clk_sys = ~clk_sys;
   // remembers a control takeover request while the faults of the current reaction stand
   always @(posedge clk_sys) took <= take || (took && faults != 4'h0);

   fsp_axis_fault_stop fsp_axis_fault_stop_i (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .board_emergency_request(faults[0]), .cmd_rate_fault(faults[1]), .pos_overtravel_fault(faults[2]),
      .neg_overtravel_fault(faults[3]), .host_follow_active(host), .builtin_ctrl_ready(ready),
      .stop_complete(complete), .move_end(move_end), .move_positioning(move_pos), .homing_active(homing),
      .ctrl_takeover(take), .stop_request(stop_req), .stop_immediate(stop_imm), .servo_off(srv_off),
      .abort_decel_time(decel), .settle_wait_start(settle_pulse));
   fsp_motion_core_model fsp_motion_core_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl_takeover(take),
      .stop_request(stop_req), .delay(delay), .builtin_ctrl_ready(ready), .stop_complete(complete));

   // ----------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------
   task automatic stop_test();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // waits on a design output under a bound; a hang ends the run
   task automatic wait_for(ref logic sig, input logic lvl);
      n = 0;
      while (sig !== lvl && n < 60) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 60) begin
         miscompares++;
         stop_test();
      end
   endtask : wait_for

   // one classic cycle: hold everything until ack is sampled, then release for a cycle
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hF;
      @(posedge clk_sys);
      wait_for(ack, 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rd_chk

   // runs one fault reaction; mid rewrites the policy while the reaction is running
   task automatic react(input logic [1:0] s, input logic [2:0] c, input logic h, input logic mid);
      logic [3:0] extra;
      wb(1'b1, {4'h0, s, 2'h0}, {29'h0, c});
      extra = 4'($urandom) & ~((4'h2 << s) - 4'h1);
      @(posedge clk_sys);
      host <= h;
      delay <= mid ? 4'h7 : 4'($urandom % 3);
      faults <= (4'h1 << s) | extra;
      if (mid) wb(1'b1, {4'h0, s, 2'h0}, {29'h0, (c == 3'h5) ? 3'h0 : c + 3'h1});
      wait_for(stop_req, 1'b1);
      check(took, h);
      check(stop_imm, c >= FSP_POL_HIGH_MIN);
      check(srv_off, c == 3'h2 || c == 3'h5);
      wait_for(stop_req, 1'b0);
      @(posedge clk_sys);
      @(posedge clk_sys);
      check(srv_off, c != 3'h0 && c != 3'h3);
      // captured source, code and mode stay visible while the faults are held
      rd_chk(FSP_OFF_STATUS, {23'h0, (c != 3'h0 && c != 3'h3), h, c, s, FSP_ST_DONE});
      faults <= 4'h0;
      @(posedge clk_sys);
      wait_for(srv_off, 1'b0);
      repeat (2) @(posedge clk_sys);
   endtask : react

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      void'($urandom(32'h4BAC));
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      // reset values, then refused and boundary writes
      rd_chk(FSP_OFF_EMG_POL, 32'h0);
      rd_chk(FSP_OFF_CMD_POL, 32'h1);
      rd_chk(FSP_OFF_POS_POL, 32'h1);
      rd_chk(FSP_OFF_NEG_POL, 32'h1);
      rd_chk(FSP_OFF_DECEL, 32'h1);
      rd_chk(FSP_OFF_SETTLE, 32'h1);
      wb(1'b1, FSP_OFF_EMG_POL, 32'h6);
      rd_chk(FSP_OFF_EMG_POL, 32'h0);
      wb(1'b1, FSP_OFF_NEG_POL, 32'h7);
      rd_chk(FSP_OFF_NEG_POL, 32'h1);
      wb(1'b1, FSP_OFF_POS_POL, 32'h5);
      rd_chk(FSP_OFF_POS_POL, 32'h5);
      wb(1'b1, FSP_OFF_DECEL, 32'h0);
      rd_chk(FSP_OFF_DECEL, 32'h1);
      wb(1'b1, FSP_OFF_DECEL, 32'h270F);
      // the write lands at the ack edge, so the output is looked at one edge later
      @(posedge clk_sys);
      check(decel, 32'h270F);
      wb(1'b1, FSP_OFF_DECEL, 32'h2710);
      rd_chk(FSP_OFF_DECEL, 32'h270F);
      // upper bits set: refused although the low field alone would be legal
      wb(1'b1, FSP_OFF_DECEL, 32'h0001_0005);
      rd_chk(FSP_OFF_DECEL, 32'h270F);
      exp_dec = 32'h1 + 32'($urandom % 9999);
      wb(1'b1, FSP_OFF_DECEL, exp_dec);
      @(posedge clk_sys);
      check(decel, exp_dec);
      rd_chk(8'h1C, 32'h0);
      // every code in both operating modes, random source and lower-priority extras
      for (int h = 0; h < 2; h++) begin
         for (int c = 0; c < 6; c++) begin
            src = 2'($urandom % 4);
            react(src, 3'(c), 1'(h), 1'($urandom % 2));
         end
      end
      react(FSP_SRC_NEG, 3'h4, 1'b1, 1'b1);
      // settling wait over every enable, positioning and homing combination
      for (int k = 0; k < 8; k++) begin
         wb(1'b1, FSP_OFF_SETTLE, {31'h0, k[2]});
         @(posedge clk_sys);
         move_end <= 1'b1;
         move_pos <= k[0];
         homing <= k[1];
         @(posedge clk_sys);
         move_end <= 1'b0;
         @(posedge clk_sys);
         check(settle_pulse, k[1] || (k[0] && k[2]));
         @(posedge clk_sys);
         check(settle_pulse, 1'b0);
      end
      stop_test();
   end
endmodule : fsp_axis_fault_stop_tb_top
